// [bench/dual_port_key_wakeup_gpio_bench.sv]
// Self-checking bench for the key wake-up ports.
// Assumes the pad model stands on the pin side and a short filter period.
`timescale 1ns/10ps
`default_nettype none
module dual_port_key_wakeup_gpio_bench;
	localparam int FC = 9;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	kwu_pkg::bus_req_t bus_req = '0;
	logic [7:0] rd_data;
	kwu_pkg::port_pair_t pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
	logic stop_mode = 1'b0;
	logic irq;
	logic [15:0] ext_drive = 16'h0000;
	logic [15:0] ext_level = 16'h0000;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [7:0] tbl [6] = '{8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2a, 8'h2b};
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	dual_port_key_wakeup_gpio #(.FILTER_CYCLES(FC)) i_dual_port_key_wakeup_gpio (
		.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .stop_mode(stop_mode), .irq(irq));
	pad_model i_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .ext_drive(ext_drive), .ext_level(ext_level),
		.pad(pin_in));
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic cmp(string what, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (e !== s) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : cmp
	task automatic op(logic [7:0] a, logic [7:0] d, logic w, logic r);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
	endtask : op
	task automatic wr(logic [7:0] a, logic [7:0] d);
		op(a, d, 1'b1, 1'b0);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		exp_q.push_back(e);
		op(a, 8'h00, 1'b0, 1'b1);
	endtask : rd
	task automatic idle(int n);
		op(8'h00, 8'h00, 1'b0, 1'b0);
		repeat (n) @(posedge clk_sys);
	endtask : idle
	task automatic wait_irq(logic e);
		int k;
		op(8'h00, 8'h00, 1'b0, 1'b0);
		for (k = 0; k < 60 && irq !== e; k++) @(negedge clk_sys);
		@(posedge clk_sys);
		cmp("irq", {15'h0000, e}, {15'h0000, irq});
		if (k == 60) results();
	endtask : wait_irq
	// Read data stand only in the cycle after the strobe.
	always @(posedge clk_sys) begin
		if (rd_q) cmp("rd_data", {8'h00, exp_q.pop_front()}, {8'h00, rd_data});
		rd_q <= bus_req.rd;
	end
	initial begin
		logic [7:0] v;
		void'($urandom(28));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		cmp("pull_up_en", 16'hffff, pull_up_en);
		for (int i = 0; i < 6; i++) rd(8'h2a + i[7:0], 8'h00);
		wr(8'h40, 8'h5a);
		rd(8'h40, 8'h00);
		rd(8'h28, 8'hff);
		$display("test reset done");
		wr(8'h2a, 8'hff);
		wr(8'h2b, 8'hff);
		idle(2);
		cmp("pin_oe", 16'hffff, pin_oe);
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom);
			wr(tbl[i], v);
			rd(tbl[i], v);
		end
		wr(8'h2c, 8'h00);
		wr(8'h2d, 8'h00);
		wr(8'h2a, 8'h00);
		wr(8'h2b, 8'h00);
		idle(8);
		wr(8'h2e, 8'hff);
		wr(8'h2f, 8'hff);
		wait_irq(1'b0);
		$display("test access done");
		wr(8'h2c, 8'h08);
		ext_drive <= 16'h2008;
		wait_irq(1'b1);
		rd(8'h2e, 8'h08);
		rd(8'h2f, 8'h20);
		wr(8'h2e, 8'h00);
		wr(8'h2e, 8'h08);
		idle(3);
		cmp("irq", 16'h0000, {15'h0000, irq});
		wr(8'h2d, 8'h20);
		wait_irq(1'b1);
		wr(8'h2f, 8'h20);
		wait_irq(1'b0);
		ext_drive <= 16'h2009;
		wr(8'h30, 8'h01);
		idle(8);
		wr(8'h2e, 8'hff);
		idle(2);
		cmp("pull_down_en", 16'h0001, pull_down_en);
		ext_level <= 16'h0001;
		idle(8);
		rd(8'h2e, 8'h01);
		wr(8'h2a, 8'h80);
		wr(8'h28, 8'h80);
		idle(8);
		cmp("pin_out", 16'h0080, {8'h00, pin_out.j});
		wr(8'h2e, 8'hff);
		wr(8'h28, 8'h00);
		idle(8);
		rd(8'h2e, 8'h80);
		wr(8'h2a, 8'h00);
		wr(8'h30, 8'h00);
		ext_drive <= 16'h0000;
		idle(8);
		wr(8'h2e, 8'hff);
		wr(8'h2f, 8'hff);
		wr(8'h2d, 8'h00);
		$display("test edges done");
		wr(8'h2c, 8'h02);
		idle(2);
		stop_mode <= 1'b1;
		ext_drive <= 16'h0002;
		ext_level <= 16'h0000;
		repeat (4) @(posedge clk_sys);
		ext_drive <= 16'h0000;
		idle(3 * FC);
		rd(8'h2e, 8'h00);
		ext_drive <= 16'h0002;
		wait_irq(1'b1);
		rd(8'h2e, 8'h02);
		stop_mode <= 1'b0;
		ext_drive <= 16'h0000;
		idle(8);
		wr(8'h2e, 8'h02);
		wait_irq(1'b0);
		idle(4);
		$display("test stop done");
		results();
	end
endmodule : dual_port_key_wakeup_gpio_bench
`default_nettype wire

// [bench/dual_port_key_wakeup_gpio_properties.sv]
// Port-level checker for the key wake-up ports, bound into the top module.
// Assumes kwu_params.svh is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "kwu_params.svh"
module dual_port_key_wakeup_gpio_checker #(
	parameter int FILTER_CYCLES = 30
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port.
	input wire kwu_pkg::bus_req_t bus_req,
	input wire logic [`KWU_DATA_W-1:0] rd_data,
	// Pads and request.
	input wire kwu_pkg::port_pair_t pin_in,
	input wire kwu_pkg::port_pair_t pin_out,
	input wire kwu_pkg::port_pair_t pin_oe,
	input wire kwu_pkg::port_pair_t pull_up_en,
	input wire kwu_pkg::port_pair_t pull_down_en,
	input wire logic stop_mode,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic dir_wr;
	logic data_wr;
	assign dir_wr = bus_req.wr && (bus_req.addr == 8'h2a || bus_req.addr == 8'h2b);
	assign data_wr = bus_req.wr && (bus_req.addr == 8'h28 || bus_req.addr == 8'h29);
	property p_rd_idle;
		!$past(bus_req.rd) |-> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped;
		$past(bus_req.rd) && ($past(bus_req.addr) > 8'h31 || $past(bus_req.addr) < 8'h28)
			|-> rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_oe_cause;
		$changed(pin_oe) |-> $past(dir_wr) || $past(dir_wr, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("drive changed unasked");
	property p_out_cause;
		$changed(pin_out) |-> $past(data_wr) || $past(data_wr, 2);
	endproperty
	a_out_cause: assert property (p_out_cause) else $error("output latch changed");
	property p_pull_excl;
		(pull_up_en & pull_down_en) == 16'h0000;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
	property p_pull_oe;
		((pull_up_en | pull_down_en) & pin_oe) == 16'h0000;
	endproperty
	a_pull_oe: assert property (p_pull_oe) else $error("pull on a driven pin");
	property p_irq_fall;
		$fell(irq) |-> $past(bus_req.wr) || $past(bus_req.wr, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("request dropped unasked");
	property p_rst_state;
		$rose(rst_n) |-> pin_oe == 16'h0000 && pull_up_en == 16'hffff && !irq;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
	c_irq: cover property ($rose(irq));
	c_stop_irq: cover property (stop_mode && $rose(irq));
	c_dir: cover property (dir_wr);
endmodule : dual_port_key_wakeup_gpio_checker
bind dual_port_key_wakeup_gpio dual_port_key_wakeup_gpio_checker #(
	.FILTER_CYCLES(FILTER_CYCLES)
) i_dual_port_key_wakeup_gpio_checker (.clk_sys(clk_sys), .rst_n(rst_n),
	.bus_req(bus_req), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
	.stop_mode(stop_mode), .irq(irq));
`default_nettype wire

// [bench/pad_model.sv]
// Pad model: external drivers, pull resistors and the block's own drivers.
// Assumes the bench sets ext_drive and ext_level for each pin.
`timescale 1ns/10ps
`default_nettype none
module pad_model (
	// Block side.
	input wire kwu_pkg::port_pair_t pin_out,
	input wire kwu_pkg::port_pair_t pin_oe,
	input wire kwu_pkg::port_pair_t pull_up_en,
	input wire kwu_pkg::port_pair_t pull_down_en,
	// Bench side.
	input wire logic [15:0] ext_drive,
	input wire logic [15:0] ext_level,
	output kwu_pkg::port_pair_t pad
);
	logic flip = 1'b0;
	// A pad left floating toggles, so a stale level is never mistaken for a driven one.
	initial begin
		forever #3 flip = ~flip;
	end
	assign pad = (pin_oe & pin_out)
		| (~pin_oe & ext_drive & ext_level)
		| (~pin_oe & ~ext_drive & (pull_up_en | (~pull_down_en & {16{flip}})));
endmodule : pad_model
`default_nettype wire

// [logic/dual_port_key_wakeup_gpio.sv]
// Two eight-bit ports with direction control and key wake-up interrupt.
// Assumes a single-cycle register master and asynchronous pad inputs.
`timescale 1ns/10ps
`default_nettype none
`include "kwu_params.svh"

module dual_port_key_wakeup_gpio #(
	parameter int FILTER_CYCLES = `KWU_FILTER_CYCLES
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port.
	input wire kwu_pkg::bus_req_t bus_req,
	output logic [`KWU_DATA_W-1:0] rd_data,
	// Pads, port J in the low byte and port H in the high byte.
	input wire kwu_pkg::port_pair_t pin_in,
	output kwu_pkg::port_pair_t pin_out,
	output kwu_pkg::port_pair_t pin_oe,
	output kwu_pkg::port_pair_t pull_up_en,
	output kwu_pkg::port_pair_t pull_down_en,
	// Power state and wake-up request.
	input wire logic stop_mode,
	output logic irq
);

	localparam int PINS = 2 * `KWU_PORT_W;
	localparam int SLOT = FILTER_CYCLES / `KWU_FILTER_VOTES;

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------

	logic [PINS-1:0] out_latch;
	logic [PINS-1:0] direction;
	logic [PINS-1:0] wake_enable;
	logic [PINS-1:0] edge_flags;
	logic [PINS-1:0] edge_polarity;
	logic [PINS-1:0] pin_level;
	logic [PINS-1:0] next_flags;
	logic [PINS-1:0] flag_set;
	logic [PINS-1:0] flag_clr;

	logic wr_j_data;
	logic wr_h_data;

	assign wr_j_data = bus_req.wr && (bus_req.addr == `KWU_OFF_J_DATA);
	assign wr_h_data = bus_req.wr && (bus_req.addr == `KWU_OFF_H_DATA);

	// The data latch is cleared so that the pads are defined, but software must not rely on it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_latch <= `KWU_RST_PAIR;
		end else begin
			if (wr_j_data) begin
				out_latch[7:0] <= bus_req.wdata;
			end
			if (wr_h_data) begin
				out_latch[15:8] <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			direction <= `KWU_RST_PAIR;
		end else if (bus_req.wr) begin
			if (bus_req.addr == `KWU_OFF_J_DIR) begin
				direction[7:0] <= bus_req.wdata;
			end
			if (bus_req.addr == `KWU_OFF_H_DIR) begin
				direction[15:8] <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_enable <= `KWU_RST_PAIR;
		end else if (bus_req.wr) begin
			if (bus_req.addr == `KWU_OFF_J_EN) begin
				wake_enable[7:0] <= bus_req.wdata;
			end
			if (bus_req.addr == `KWU_OFF_H_EN) begin
				wake_enable[15:8] <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			edge_polarity <= `KWU_RST_PAIR;
		end else if (bus_req.wr) begin
			if (bus_req.addr == `KWU_OFF_J_POL) begin
				edge_polarity[7:0] <= bus_req.wdata;
			end
			if (bus_req.addr == `KWU_OFF_H_POL) begin
				edge_polarity[15:8] <= bus_req.wdata;
			end
		end
	end

	// --------------------------------------------------------------
	// Pad synchronisers
	// --------------------------------------------------------------

	logic [PINS-1:0] sync_a;
	logic [PINS-1:0] sync_b;
	logic [PINS-1:0] sync_c;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= `KWU_RST_PAIR;
			sync_b <= `KWU_RST_PAIR;
			sync_c <= `KWU_RST_PAIR;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// A pin level only moves once two settled stages agree, so a metastable sample never counts.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_level <= `KWU_RST_PAIR;
		end else begin
			pin_level <= (sync_b & sync_c) | (pin_level & (sync_b ^ sync_c));
		end
	end

	// --------------------------------------------------------------
	// Edge detection
	// --------------------------------------------------------------

	logic [PINS-1:0] trig_level;
	logic [PINS-1:0] trig_prev;
	logic [PINS-1:0] active_edge;

	// Pads are watched whatever the direction, so an output pin can wake the part too.
	assign trig_level = (pin_level & edge_polarity) | (~pin_level & ~edge_polarity);
	assign active_edge = trig_level & ~trig_prev;

	// Comparing against the polarity-qualified level means that flipping a polarity bit can
	// itself raise a flag; software clears the flags after setting the polarity.
	// The previous level resets high, as the reset trigger level is, so release sets no flag.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trig_prev <= {PINS{1'b1}};
		end else begin
			trig_prev <= trig_level;
		end
	end

	// --------------------------------------------------------------
	// Stop-mode filter
	// --------------------------------------------------------------

	kwu_pkg::filt_state_t filt_state;
	logic [7:0] filt_cnt;
	logic [1:0] votes;
	logic [PINS-1:0] pending;
	logic any_trig;
	logic any_start;
	logic sample_now;
	logic period_end;
	logic [1:0] next_votes;
	logic [PINS-1:0] filt_set;

	assign any_trig = |(trig_level & wake_enable);
	assign any_start = |(active_edge & wake_enable);
	assign sample_now = (filt_cnt == 8'(SLOT - 1)) || (filt_cnt == 8'(2 * SLOT - 1))
		|| (filt_cnt == 8'(3 * SLOT - 1));
	assign period_end = filt_cnt == 8'(3 * SLOT - 1);
	assign next_votes = votes + {1'b0, any_trig};

	always_comb begin
		filt_set = `KWU_RST_PAIR;
		if (filt_state == kwu_pkg::FILT_RUN && period_end
			&& next_votes >= 2'(`KWU_FILTER_ACCEPT)) begin
			filt_set = pending | (active_edge & wake_enable);
		end
	end

	// One shared filter serves all pins: a second pulse inside a running period is merged.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			filt_state <= kwu_pkg::FILT_IDLE;
			filt_cnt <= 8'h00;
			votes <= 2'h0;
			pending <= `KWU_RST_PAIR;
		end else begin
			unique case (filt_state)
				kwu_pkg::FILT_IDLE: begin
					filt_cnt <= 8'h00;
					votes <= 2'h0;
					pending <= `KWU_RST_PAIR;
					if (stop_mode && any_start) begin
						filt_state <= kwu_pkg::FILT_RUN;
						pending <= active_edge & wake_enable;
					end
				end
				kwu_pkg::FILT_RUN: begin
					pending <= pending | (active_edge & wake_enable);
					if (sample_now) begin
						votes <= next_votes;
					end
					if (period_end || !stop_mode) begin
						filt_state <= kwu_pkg::FILT_IDLE;
						filt_cnt <= 8'h00;
					end else begin
						filt_cnt <= filt_cnt + 8'h01;
					end
				end
				default: begin
					filt_state <= kwu_pkg::FILT_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Edge flags and interrupt
	// --------------------------------------------------------------

	// In stop mode only the filter may set a flag; otherwise every active edge does.
	assign flag_set = stop_mode ? filt_set : active_edge;

	always_comb begin
		flag_clr = `KWU_RST_PAIR;
		if (bus_req.wr && bus_req.addr == `KWU_OFF_J_FLAG) begin
			flag_clr[7:0] = bus_req.wdata;
		end
		if (bus_req.wr && bus_req.addr == `KWU_OFF_H_FLAG) begin
			flag_clr[15:8] = bus_req.wdata;
		end
		next_flags = (edge_flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			edge_flags <= `KWU_RST_PAIR;
		end else begin
			edge_flags <= next_flags;
		end
	end

	// One request for all sixteen pins; it serves stop and wait alike.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_flags & wake_enable);
		end
	end

	// --------------------------------------------------------------
	// Pads
	// --------------------------------------------------------------

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= `KWU_RST_PAIR;
			pin_oe <= `KWU_RST_PAIR;
			pull_up_en <= {PINS{1'b1}};
			pull_down_en <= `KWU_RST_PAIR;
		end else begin
			pin_out <= out_latch;
			pin_oe <= direction;
			pull_up_en <= ~edge_polarity & ~direction;
			pull_down_en <= edge_polarity & ~direction;
		end
	end

	// --------------------------------------------------------------
	// Read port
	// --------------------------------------------------------------

	logic [PINS-1:0] data_view;

	assign data_view = (direction & out_latch) | (~direction & pin_level);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `KWU_RST_BYTE;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				`KWU_OFF_J_DATA: rd_data <= data_view[7:0];
				`KWU_OFF_H_DATA: rd_data <= data_view[15:8];
				`KWU_OFF_J_DIR: rd_data <= direction[7:0];
				`KWU_OFF_H_DIR: rd_data <= direction[15:8];
				`KWU_OFF_J_EN: rd_data <= wake_enable[7:0];
				`KWU_OFF_H_EN: rd_data <= wake_enable[15:8];
				`KWU_OFF_J_FLAG: rd_data <= edge_flags[7:0];
				`KWU_OFF_H_FLAG: rd_data <= edge_flags[15:8];
				`KWU_OFF_J_POL: rd_data <= edge_polarity[7:0];
				`KWU_OFF_H_POL: rd_data <= edge_polarity[15:8];
				default: rd_data <= `KWU_RST_BYTE;
			endcase
		end else begin
			rd_data <= `KWU_RST_BYTE;
		end
	end

endmodule : dual_port_key_wakeup_gpio
`default_nettype wire

// [logic/kwu_params.svh]
// Offsets, widths, reset values and timing counts of the key wake-up ports.
// Assumes an 8-bit byte-addressed register port and a 100 MHz bus clock.
//
// Notes on behaviour
// - Sixteen pins as two eight-bit ports.
// - Wake-up triggered by rising or falling edge.
// - Request when flag and enable both set.
// - All pins share one interrupt request.
// - Request wakes from stop and wait.
// - Stop-mode path free of register-access alignment.
// - Filter rejects short pulses in stop.
// - Detection works for inputs and outputs alike.
// - Direction 0 input, 1 output, resets 0.
// - Second direction register identical, always accessible.
// - Enable bits gate interrupt, reset 0.
// - Data registers always accessible, no reset value; the data latch here is cleared at reset.
// - Registers at fixed offsets from port J.
// - Edge sets flag, write one clears.
// - Polarity 0 falling plus pull-up, 1 rising plus pull-down.
// - Three samples per period, two accept.
// - Enabled edge starts shared filter oscillator.
`ifndef KWU_PARAMS_SVH
`define KWU_PARAMS_SVH

`define KWU_ADDR_W 8
`define KWU_DATA_W 8
`define KWU_PORT_W 8

`define KWU_OFF_J_DATA 8'h28
`define KWU_OFF_H_DATA 8'h29
`define KWU_OFF_J_DIR 8'h2a
`define KWU_OFF_H_DIR 8'h2b
`define KWU_OFF_J_EN 8'h2c
`define KWU_OFF_H_EN 8'h2d
`define KWU_OFF_J_FLAG 8'h2e
`define KWU_OFF_H_FLAG 8'h2f
`define KWU_OFF_J_POL 8'h30
`define KWU_OFF_H_POL 8'h31

`define KWU_RST_BYTE 8'h00
`define KWU_RST_PAIR 16'h0000

`define KWU_CLK_PERIOD_NS 10
`define KWU_FILTER_PERIOD_NS 300
`define KWU_FILTER_CYCLES (`KWU_FILTER_PERIOD_NS / `KWU_CLK_PERIOD_NS)
`define KWU_FILTER_VOTES 3
`define KWU_FILTER_ACCEPT 2

`endif

// [logic/kwu_pkg.sv]
// Types shared by the key wake-up port block.
// Assumes kwu_params.svh is on the include path.
`include "kwu_params.svh"

package kwu_pkg;

	typedef struct packed {
		logic [`KWU_ADDR_W-1:0] addr;
		logic [`KWU_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic [`KWU_PORT_W-1:0] h;
		logic [`KWU_PORT_W-1:0] j;
	} port_pair_t;

	typedef enum logic [1:0] {
		FILT_IDLE = 2'b01,
		FILT_RUN = 2'b10
	} filt_state_t;

endpackage : kwu_pkg
